// ---- hdl/dfpm_map.svh ----
// constants for the drive fault protection monitor: times, percents, fault codes
// assumes a 20 MHz control clock and percent-of-rated-current measurements
`ifndef DFPM_MAP_SVH
`define DFPM_MAP_SVH

// ***************************************************
// timing
// ***************************************************
`define DFPM_CLK_HZ 20000000
`define DFPM_TICK_MS 100
`define DFPM_TICK_CYCLES (`DFPM_CLK_HZ / 1000 * `DFPM_TICK_MS)
`define DFPM_TICKS_PER_S (1000 / `DFPM_TICK_MS)
`define DFPM_IPH_PERSIST_S 180
`define DFPM_OPH_PERSIST_MS 1000
`define DFPM_OPH_PERSIST_TICKS (`DFPM_OPH_PERSIST_MS / `DFPM_TICK_MS)

// ***************************************************
// thresholds and defaults
// ***************************************************
`define DFPM_EARLY_NUM 7
`define DFPM_EARLY_DEN 10
`define DFPM_OT_LEVEL_DEF 8'h82
`define DFPM_OT_TIME_DEF 7'h05
`define DFPM_UC_HYST_DEF 5'h0a

// ***************************************************
// fault codes
// ***************************************************
`define DFPM_FC_NONE 8'h00
`define DFPM_FC_IPH 8'h29
`define DFPM_FC_UC 8'h0c
`define DFPM_FC_OT 8'h07
`define DFPM_FC_OC 8'h11
`define DFPM_FC_OPH 8'h08

`endif

// ---- hdl/dfpm_pkg.sv ----
// types shared by the protection monitor modules
// assumes dfpm_map.svh is compiled alongside
package dfpm_pkg;
    typedef enum logic [2:0] {
        DFPM_OPH_OFF,
        DFPM_OPH_FIRST,
        DFPM_OPH_EACH,
        DFPM_OPH_RUN,
        DFPM_OPH_START_RUN,
        DFPM_OPH_CUTOFF
    } dfpm_oph_mode_t;

    typedef enum logic [1:0] {
        DFPM_CUT_IDLE,
        DFPM_CUT_LOST,
        DFPM_CUT_RESTART
    } dfpm_cut_t;
endpackage : dfpm_pkg

// ---- hdl/dfpm_persist.sv ----
// persistence timer: counts ticks while a condition holds
// assumes tick is a one-cycle pulse from the same clock domain
`timescale 1ns/100ps
module dfpm_persist
    import dfpm_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic cond,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [W:0] cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!cond) begin
            cnt_r <= '0;
        end else if (tick && !(&cnt_r)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // one extra tick so the first partial tick never shortens the time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= cond && (cnt_r > {1'b0, limit});
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    timer_clear_a: assert property (!cond |=> cnt_r == '0 && !expired)
        else $error("persistence count kept after condition dropped");
endmodule : dfpm_persist

// ---- hdl/dfpm_monitor.sv ----
// drive fault protection monitor top: phase loss, undercurrent, over-torque
// assumes currents in percent of motor rated current from same-clock logic;
// phase status lines come from pins and are synchronised here
`timescale 1ns/100ps
`include "dfpm_map.svh"
module dfpm_monitor
    import dfpm_pkg::*;
#(
    parameter int TICK_CYCLES = `DFPM_TICK_CYCLES,
    parameter int IPH_TICKS = `DFPM_IPH_PERSIST_S * `DFPM_TICKS_PER_S,
    parameter bit SINGLE_PHASE = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic input_phase_check_sel,
    input wire logic [2:0] output_phase_check_mode,
    input wire logic underload_response_sel,
    input wire logic [6:0] undercurrent_level,
    input wire logic [4:0] undercurrent_hysteresis,
    input wire logic [7:0] undercurrent_time,
    input wire logic [2:0] overload_indication_sel,
    input wire logic [7:0] overtorque_level,
    input wire logic [6:0] overtorque_time,
    input wire logic [8:0] torque_current,
    input wire logic [8:0] output_current,
    input wire logic cap_voltage_abnormal,
    input wire logic out_phase_loss,
    input wire logic out_all_phase_loss,
    input wire logic run_active,
    input wire logic start_active,
    input wire logic autotune_active,
    input wire logic dip_restart,
    input wire logic fault_reset,
    output logic relay_early_alarm,
    output logic relay_overtorque,
    output logic underload_alarm,
    output logic trip,
    output logic [7:0] fault_code,
    output logic stop_req,
    output logic out_cutoff,
    output logic restart_req
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int IW = $clog2(IPH_TICKS + 1);

    // ***************************************************
    // reset release and pin synchronisers
    // ***************************************************
    logic rst_meta_r;
    logic rst_n;
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_raw;
    logic cap_abn;
    logic oph_loss;
    logic oph_all;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    assign pin_raw = {out_all_phase_loss, out_phase_loss, cap_voltage_abnormal};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end else begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    assign cap_abn = pin_sync_r[0];
    assign oph_loss = pin_sync_r[1];
    assign oph_all = pin_sync_r[2];

    // ***************************************************
    // time base: one pulse per tick period
    // ***************************************************
    logic [TW-1:0] pre_r;
    logic tick_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
            tick_r <= 1'b0;
        end else if (pre_r == TW'(TICK_CYCLES - 1)) begin
            pre_r <= '0;
            tick_r <= 1'b1;
        end else begin
            pre_r <= pre_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // ***************************************************
    // input phase loss
    // ***************************************************
    logic iph_cond;
    logic iph_exp;

    // check gated by setting and build
    assign iph_cond = cap_abn && input_phase_check_sel && !SINGLE_PHASE && run_active;

    dfpm_persist #(.W(IW)) u_iph (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_r),
        .cond(iph_cond),
        .limit(IW'(IPH_TICKS)),
        .expired(iph_exp)
    );

    // ***************************************************
    // output phase loss
    // ***************************************************
    logic first_run_r;
    logic oph_window;
    logic oph_exp;
    dfpm_oph_mode_t oph_mode;
    dfpm_cut_t cut_r;

    assign oph_mode = dfpm_oph_mode_t'(output_phase_check_mode);

    // first start after power-up ends when start-up finishes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_run_r <= 1'b1;
        end else if (run_active && !start_active) begin
            first_run_r <= 1'b0;
        end
    end

    always_comb begin
        unique case (oph_mode)
            DFPM_OPH_FIRST: oph_window = start_active && first_run_r;
            DFPM_OPH_EACH: oph_window = start_active;
            DFPM_OPH_RUN: oph_window = run_active && !start_active;
            DFPM_OPH_START_RUN: oph_window = run_active || start_active;
            default: oph_window = 1'b0;
        endcase
        if (autotune_active) begin
            oph_window = 1'b1;
        end
    end

    dfpm_persist #(.W(8)) u_oph (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_r),
        .cond(oph_loss && oph_window),
        .limit(8'(`DFPM_OPH_PERSIST_TICKS)),
        .expired(oph_exp)
    );

    // cutoff detection and restart on reconnection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cut_r <= DFPM_CUT_IDLE;
        end else begin
            unique case (cut_r)
                DFPM_CUT_IDLE: begin
                    if (oph_mode == DFPM_OPH_CUTOFF && run_active && !dip_restart && oph_all) begin
                        cut_r <= DFPM_CUT_LOST;
                    end
                end
                DFPM_CUT_LOST: begin
                    if (!oph_all) begin
                        cut_r <= DFPM_CUT_RESTART;
                    end
                end
                DFPM_CUT_RESTART: cut_r <= DFPM_CUT_IDLE;
                default: cut_r <= DFPM_CUT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_cutoff <= 1'b0;
            restart_req <= 1'b0;
        end else begin
            out_cutoff <= (cut_r == DFPM_CUT_LOST);
            restart_req <= (cut_r == DFPM_CUT_RESTART);
        end
    end

    // ***************************************************
    // undercurrent
    // ***************************************************
    logic uc_below;
    logic uc_above;
    logic uc_exp;
    logic uc_alarm_r;

    // level and band in percent of rated current
    assign uc_below = output_current < {2'b00, undercurrent_level};
    assign uc_above = output_current > (9'(undercurrent_level) + 9'(undercurrent_hysteresis));

    dfpm_persist #(.W(12)) u_uc (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_r),
        .cond(uc_below && run_active),
        .limit(12'(undercurrent_time * `DFPM_TICKS_PER_S)),
        .expired(uc_exp)
    );

    // clears past the hysteresis band or when the drive stops running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uc_alarm_r <= 1'b0;
        end else if (uc_exp) begin
            uc_alarm_r <= 1'b1;
        end else if (uc_above || !run_active) begin
            uc_alarm_r <= 1'b0;
        end
    end

    // alarm terminal in either response setting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            underload_alarm <= 1'b0;
        end else begin
            underload_alarm <= uc_alarm_r;
        end
    end

    // ***************************************************
    // over-torque / over-current
    // ***************************************************
    logic [8:0] cmp_cur;
    logic at_early;
    logic at_full;
    logic ot_exp;
    logic ot_valid;

    // settings 3 and up use output current
    assign cmp_cur = (overload_indication_sel < 3'h3) ? torque_current : output_current;
    assign ot_valid = overload_indication_sel <= 3'h5;
    // level in percent of rated current
    assign at_full = {1'b0, cmp_cur} >= {2'b00, overtorque_level};
    assign at_early = (13'(cmp_cur) * 13'(`DFPM_EARLY_DEN))
        >= (13'(overtorque_level) * 13'(`DFPM_EARLY_NUM));

    // time in tenths of a second
    dfpm_persist #(.W(7)) u_ot (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_r),
        .cond(at_full && ot_valid),
        .limit(overtorque_time),
        .expired(ot_exp)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_early_alarm <= 1'b0;
        end else if (!ot_valid) begin
            relay_early_alarm <= 1'b0;
        end else if (overload_indication_sel == 3'h2 || overload_indication_sel == 3'h5) begin
            relay_early_alarm <= at_full;
        end else begin
            relay_early_alarm <= at_early;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_overtorque <= 1'b0;
        end else begin
            relay_overtorque <= ot_exp;
        end
    end

    // ***************************************************
    // trip latch; first fault keeps its code, a new fault beats a reset
    // ***************************************************
    logic fault_hit;
    logic [7:0] fault_new;

    always_comb begin
        fault_hit = 1'b1;
        fault_new = `DFPM_FC_NONE;
        if (iph_exp) begin
            fault_new = `DFPM_FC_IPH;
        end else if (oph_exp) begin
            fault_new = `DFPM_FC_OPH;
        end else if (uc_exp && underload_response_sel) begin
            fault_new = `DFPM_FC_UC;
        end else if (ot_exp && overload_indication_sel == 3'h1) begin
            fault_new = `DFPM_FC_OT;
        end else if (ot_exp && overload_indication_sel == 3'h4) begin
            fault_new = `DFPM_FC_OC;
        end else begin
            fault_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip <= 1'b0;
            fault_code <= `DFPM_FC_NONE;
            stop_req <= 1'b0;
        end else if (fault_hit && !trip) begin
            trip <= 1'b1;
            fault_code <= fault_new;
            stop_req <= 1'b1;
        end else if (fault_reset && !fault_hit) begin
            trip <= 1'b0;
            fault_code <= `DFPM_FC_NONE;
            stop_req <= 1'b0;
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence cut_lost_s;
        cut_r == DFPM_CUT_LOST && !oph_all;
    endsequence

    early_seventy_a: assert property (
        (ot_valid && overload_indication_sel != 3'h2 && overload_indication_sel != 3'h5
            && at_early) |=> relay_early_alarm)
        else $error("early alarm missed at 70 percent");

    early_full_a: assert property (
        ((overload_indication_sel == 3'h2 || overload_indication_sel == 3'h5) && !at_full)
            |=> !relay_early_alarm)
        else $error("early alarm below full level");

    relay_cause_a: assert property ($rose(relay_overtorque) |-> $past(at_full, 2))
        else $error("overtorque relay without full level");

    torque_stop_a: assert property (
        (ot_exp && !trip && !iph_exp && !oph_exp && !(uc_exp && underload_response_sel)
            && overload_indication_sel == 3'h1) |=> trip && fault_code == `DFPM_FC_OT)
        else $error("torque fault not reported");

    no_stop_a: assert property (
        ($rose(trip)) |-> fault_code != `DFPM_FC_OT || $past(overload_indication_sel) == 3'h1)
        else $error("torque fault in alarm-only setting");

    iph_gate_a: assert property (
        ($rose(trip) && fault_code == `DFPM_FC_IPH) |-> $past(input_phase_check_sel, 2))
        else $error("input phase trip while check disabled");

    uc_trip_a: assert property (
        ($rose(trip) && fault_code == `DFPM_FC_UC) |-> $past(underload_response_sel))
        else $error("undercurrent trip in alarm-only setting");

    uc_hold_a: assert property (
        (uc_alarm_r && !uc_above && run_active) |=> uc_alarm_r)
        else $error("undercurrent alarm cleared inside band");

    cut_restart_a: assert property (cut_lost_s |=> ##1 restart_req ##1 !restart_req)
        else $error("restart pulse after reconnection wrong");
endmodule : dfpm_monitor

// ---- tb/dfpm_motor_model.sv ----
// stand-in for the motor power stage: currents and phase status seen by the monitor
// assumes bench commands change on the falling edge; the stage answers on the rising edge
`timescale 1ns/100ps
module dfpm_motor_model (
    input wire logic clk,
    input wire logic stop_req,
    input wire logic [8:0] cmd_torque,
    input wire logic [8:0] cmd_output,
    input wire logic cmd_cap_bad,
    input wire logic cmd_phase_loss,
    input wire logic cmd_all_loss,
    output logic [8:0] torque_current,
    output logic [8:0] output_current,
    output logic cap_voltage_abnormal,
    output logic out_phase_loss,
    output logic out_all_phase_loss
);
    initial begin
        torque_current = 9'h000;
        output_current = 9'h000;
        cap_voltage_abnormal = 1'b0;
        out_phase_loss = 1'b0;
        out_all_phase_loss = 1'b0;
    end

    // a stopped drive feeds no current, so the load falls away at once
    always @(posedge clk) begin
        torque_current <= stop_req ? 9'h000 : cmd_torque;
        output_current <= stop_req ? 9'h000 : cmd_output;
        cap_voltage_abnormal <= cmd_cap_bad;
        out_phase_loss <= cmd_phase_loss;
        out_all_phase_loss <= cmd_all_loss;
    end
endmodule : dfpm_motor_model

// ---- tb/testbench.sv ----
// self-checking bench for the protection monitor with a motor stage model
// assumes a 10-cycle tick and a 5-tick input phase limit to keep the run short
`timescale 1ns/100ps
module testbench;
    import dfpm_pkg::*;
    localparam int LIMIT = 8000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic input_phase_check_sel, underload_response_sel, run_active, start_active;
    logic autotune_active, dip_restart, fault_reset, cmd_cap_bad, cmd_phase_loss, cmd_all_loss;
    logic [2:0] output_phase_check_mode, overload_indication_sel;
    logic [6:0] undercurrent_level, overtorque_time;
    logic [4:0] undercurrent_hysteresis;
    logic [7:0] undercurrent_time, overtorque_level, fault_code;
    logic [8:0] torque_current, output_current, cmd_torque, cmd_output;
    logic cap_voltage_abnormal, out_phase_loss, out_all_phase_loss;
    logic relay_early_alarm, relay_overtorque, underload_alarm, trip, stop_req;
    logic out_cutoff, restart_req;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    wire [6:0] obs = {restart_req, out_cutoff, stop_req, trip, underload_alarm,
                      relay_overtorque, relay_early_alarm};

    always #25 clk = ~clk;

    dfpm_monitor #(.TICK_CYCLES(10), .IPH_TICKS(5), .SINGLE_PHASE(1'b0)) dfpm_monitor_inst (
        .clk(clk), .nrst(nrst), .input_phase_check_sel(input_phase_check_sel),
        .output_phase_check_mode(output_phase_check_mode),
        .underload_response_sel(underload_response_sel), .undercurrent_level(undercurrent_level),
        .undercurrent_hysteresis(undercurrent_hysteresis), .undercurrent_time(undercurrent_time),
        .overload_indication_sel(overload_indication_sel), .overtorque_level(overtorque_level),
        .overtorque_time(overtorque_time), .torque_current(torque_current),
        .output_current(output_current), .cap_voltage_abnormal(cap_voltage_abnormal),
        .out_phase_loss(out_phase_loss), .out_all_phase_loss(out_all_phase_loss),
        .run_active(run_active), .start_active(start_active), .autotune_active(autotune_active),
        .dip_restart(dip_restart), .fault_reset(fault_reset),
        .relay_early_alarm(relay_early_alarm), .relay_overtorque(relay_overtorque),
        .underload_alarm(underload_alarm), .trip(trip), .fault_code(fault_code),
        .stop_req(stop_req), .out_cutoff(out_cutoff), .restart_req(restart_req));

    dfpm_motor_model dfpm_motor_model_inst (
        .clk(clk), .stop_req(stop_req), .cmd_torque(cmd_torque), .cmd_output(cmd_output),
        .cmd_cap_bad(cmd_cap_bad), .cmd_phase_loss(cmd_phase_loss), .cmd_all_loss(cmd_all_loss),
        .torque_current(torque_current), .output_current(output_current),
        .cap_voltage_abnormal(cap_voltage_abnormal), .out_phase_loss(out_phase_loss),
        .out_all_phase_loss(out_all_phase_loss));

    // ***************************************************
    // shared tasks
    // ***************************************************
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // bounded wait for one monitor output to go high
    task automatic wait_obs(input int idx, input int max);
        int k;
        k = 0;
        while (obs[idx] !== 1'b1 && k < max) begin
            @(negedge clk);
            k++;
        end
    endtask : wait_obs

    task automatic set_cur(input bit tq, input logic [8:0] v);
        cmd_torque = tq ? v : 9'h000;
        cmd_output = tq ? 9'h000 : v;
        idle(4);
    endtask : set_cur

    // drop every condition, then clear the latched fault
    task automatic clear_fault();
        cmd_torque = 9'h000;
        cmd_output = 9'h000;
        cmd_cap_bad = 1'b0;
        cmd_phase_loss = 1'b0;
        cmd_all_loss = 1'b0;
        run_active = 1'b0;
        start_active = 1'b0;
        autotune_active = 1'b0;
        dip_restart = 1'b0;
        idle(4);
        fault_reset = 1'b1;
        idle(1);
        fault_reset = 1'b0;
        idle(3);
    endtask : clear_fault

    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            final_report();
        end
    end

    // ***************************************************
    // scenarios
    // ***************************************************
    initial begin
        input_phase_check_sel = 1'b0;
        underload_response_sel = 1'b0;
        output_phase_check_mode = 3'h1;
        overload_indication_sel = 3'h6;
        undercurrent_level = 7'h00;
        undercurrent_hysteresis = 5'h0a;
        undercurrent_time = 8'h01;
        overtorque_level = 8'h64;
        overtorque_time = 7'h00;
        fault_reset = 1'b0;
        clear_fault();
        nrst = 1'b1;
        idle(6);
        check({2'b00, obs}, 9'h000);
        check({1'b0, fault_code}, 9'h000);
        // first start passes clean, so a later start with a lost phase is not checked
        start_active = 1'b1;
        idle(5);
        start_active = 1'b0;
        run_active = 1'b1;
        idle(5);
        run_active = 1'b0;
        start_active = 1'b1;
        cmd_phase_loss = 1'b1;
        idle(150);
        check(trip, 1'b0);
        clear_fault();
        // a second reset re-arms the first-start check of mode 1
        nrst = 1'b0;
        idle(2);
        nrst = 1'b1;
        idle(3);
        start_active = 1'b1;
        cmd_phase_loss = 1'b1;
        idle(100);
        check(trip, 1'b0);
        wait_obs(3, 40);
        check({1'b0, fault_code}, 9'h008);
        clear_fault();
        for (int m = 2; m < 5; m++) begin
            output_phase_check_mode = m[2:0];
            start_active = (m != 3);
            run_active = (m != 2);
            cmd_phase_loss = 1'b1;
            idle(100);
            check(trip, 1'b0);
            wait_obs(3, 80);
            check(trip, 1'b1);
            check({1'b0, fault_code}, 9'h008);
            clear_fault();
        end
        output_phase_check_mode = 3'h0;
        run_active = 1'b1;
        cmd_phase_loss = 1'b1;
        idle(150);
        check(trip, 1'b0);
        autotune_active = 1'b1;
        wait_obs(3, 160);
        check(trip, 1'b1);
        clear_fault();
        // cutoff mode: loss of all phases, then reconnection
        output_phase_check_mode = 3'h5;
        run_active = 1'b1;
        cmd_all_loss = 1'b1;
        wait_obs(5, 20);
        check(out_cutoff, 1'b1);
        check(trip, 1'b0);
        cmd_all_loss = 1'b0;
        wait_obs(6, 20);
        check(restart_req, 1'b1);
        idle(1);
        check(restart_req, 1'b0);
        dip_restart = 1'b1;
        cmd_all_loss = 1'b1;
        idle(20);
        check(out_cutoff, 1'b0);
        clear_fault();
        output_phase_check_mode = 3'h0;
        // input phase: trips only when enabled
        input_phase_check_sel = 1'b1;
        run_active = 1'b1;
        cmd_cap_bad = 1'b1;
        idle(50);
        check(trip, 1'b0);
        wait_obs(3, 60);
        check({1'b0, fault_code}, 9'h029);
        clear_fault();
        input_phase_check_sel = 1'b0;
        run_active = 1'b1;
        cmd_cap_bad = 1'b1;
        idle(100);
        check(trip, 1'b0);
        clear_fault();
        // undercurrent at 50 percent with 10 percent hysteresis, one second
        undercurrent_level = 7'h32;
        run_active = 1'b1;
        cmd_output = 9'h028;
        idle(80);
        check(underload_alarm, 1'b0);
        wait_obs(2, 100);
        check(underload_alarm, 1'b1);
        check(trip, 1'b0);
        set_cur(1'b0, 9'h037);
        check(underload_alarm, 1'b1);
        set_cur(1'b0, 9'h03d);
        check(underload_alarm, 1'b0);
        underload_response_sel = 1'b1;
        set_cur(1'b0, 9'h028);
        wait_obs(3, 150);
        check({1'b0, fault_code}, 9'h00c);
        clear_fault();
        undercurrent_level = 7'h00;
        // indication settings: source, early threshold, relay 32 and stop
        for (int s = 0; s < 6; s++) begin
            overload_indication_sel = s[2:0];
            set_cur(s >= 3, 9'h078);
            check(relay_early_alarm, 1'b0);
            set_cur(s < 3, 9'h045);
            check(relay_early_alarm, 1'b0);
            set_cur(s < 3, 9'h046);
            check(relay_early_alarm, !(s == 2 || s == 5));
            set_cur(s < 3, 9'h064);
            check(relay_early_alarm, 1'b1);
            wait_obs(1, 30);
            check(relay_overtorque, 1'b1);
            check(stop_req, (s == 1 || s == 4));
            check({1'b0, fault_code}, (s == 1) ? 9'h007 : (s == 4) ? 9'h011 : 9'h000);
            clear_fault();
        end
        // an interrupted over-torque restarts its timer
        overload_indication_sel = 3'h0;
        overtorque_time = 7'h05;
        set_cur(1'b1, 9'h064);
        idle(30);
        set_cur(1'b1, 9'h000);
        set_cur(1'b1, 9'h064);
        idle(30);
        check(relay_overtorque, 1'b0);
        wait_obs(1, 60);
        check(relay_overtorque, 1'b1);
        check(trip, 1'b0);
        clear_fault();
        final_report();
    end
endmodule : testbench
